// File: design/csc_map.vh
`ifndef CSC_MAP_VH
`define CSC_MAP_VH
// Register byte offsets
`define CSC_OFS_CTRL        8'h00
`define CSC_OFS_PUMP        8'h04
`define CSC_OFS_FAULT       8'h08
`define CSC_OFS_FLAG        8'h0C
`define CSC_OFS_STATUS      8'h10
// Control register fields
`define CSC_CTRL_BSD        0
`define CSC_CTRL_DLY        1
`define CSC_CTRL_RSTEN      2
`define CSC_CTRL_HIZ        3
`define CSC_CTRL_BOOST      4
`define CSC_CTRL_DEFAULTS   5
`define CSC_CTRL_MODE_LO    6
`define CSC_CTRL_MODE_HI    7
`define CSC_CTRL_MANUAL     8
`define CSC_CTRL_DPMMASK    9
`define CSC_CTRL_RESET      10'h004
// Pulse control register fields
`define CSC_PUMP_EN         0
`define CSC_PUMP_UP         1
`define CSC_PUMP_DN         2
`define CSC_PUMP_ILIM_LO    4
`define CSC_PUMP_ILIM_HI    8
`define CSC_ILIM_RESET      5'h08
// Indicator modes
`define CSC_MODE_AUTO       2'h0
`define CSC_MODE_MANUAL     2'h1
// Times as printed and cycle counts at 100 MHz
`define CSC_CLK_HZ          100000000
`define CSC_T_SHIP_DLY_S    12
`define CSC_T_SHIPMODE_S    1
`define CSC_T_QON_RST_S     10
`define CSC_T_SW_RST_MS     320
`define CSC_T_BLINK_HZ      1
`define CSC_T_ALERT_US      256
`define CSC_SHIP_DLY_CYC    (`CSC_T_SHIP_DLY_S * `CSC_CLK_HZ)
`define CSC_SHIPMODE_CYC    (`CSC_T_SHIPMODE_S * `CSC_CLK_HZ)
`define CSC_QON_RST_CYC     (`CSC_T_QON_RST_S * `CSC_CLK_HZ)
`define CSC_SW_RST_CYC      (`CSC_T_SW_RST_MS * (`CSC_CLK_HZ / 1000))
`define CSC_BLINK_HALF_CYC  (`CSC_CLK_HZ / (2 * `CSC_T_BLINK_HZ))
`define CSC_ALERT_CYC       (`CSC_T_ALERT_US * (`CSC_CLK_HZ / 1000000))
// Adaptor pulse shape, plain defaults
`define CSC_PUMP_ON_CYC     100000
`define CSC_PUMP_OFF_CYC    100000
`define CSC_UP_PULSES       3
`define CSC_DN_PULSES       2
`endif

// File: design/csc_top.v
`include "csc_map.vh"
module csc_top #(
  parameter [31:0] SHIP_DLY_CYC   = `CSC_SHIP_DLY_CYC,
  parameter [31:0] SHIPMODE_CYC   = `CSC_SHIPMODE_CYC,
  parameter [31:0] QON_RST_CYC    = `CSC_QON_RST_CYC,
  parameter [31:0] SW_RST_CYC     = `CSC_SW_RST_CYC,
  parameter [31:0] BLINK_HALF_CYC = `CSC_BLINK_HALF_CYC,
  parameter [31:0] ALERT_CYC      = `CSC_ALERT_CYC,
  parameter [31:0] PUMP_ON_CYC    = `CSC_PUMP_ON_CYC,
  parameter [31:0] PUMP_OFF_CYC   = `CSC_PUMP_OFF_CYC,
  parameter [3:0]  UP_PULSES      = `CSC_UP_PULSES,
  parameter [3:0]  DN_PULSES      = `CSC_DN_PULSES
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rstn,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Supply and charger status from analog
  input  wire        vbusValid,
  input  wire        vbusInRange,
  input  wire        aboveSleep,
  input  wire        sourceNotPoor,
  input  wire        typeDetectDone,
  input  wire        sourceDetected,
  input  wire        charging,
  input  wire        chargeDone,
  input  wire        chargeEnabled,
  input  wire        suspendInOv,
  input  wire        suspendTs,
  input  wire        suspendTimer,
  input  wire        suspendSysOv,
  input  wire        boostTsSuspend,
  input  wire        iinRegulating,
  input  wire        vinRegulating,
  // Fault sources
  input  wire        faultWatchdog,
  input  wire        faultBoost,
  input  wire        faultCharge,
  input  wire        faultBatOv,
  input  wire        thermistorFault,
  // Push-button pin
  input  wire        wakeButtonN,
  // Power path controls
  output reg         batterySwitchOn,
  output reg         inputHighImpedanceEn,
  output reg         boostOutputEnable,
  output reg         limitIs100mA,
  output reg  [4:0]  inputCurrentLimit,
  // Status pins
  output reg         inputGoodN,
  output reg         hostAlertN,
  input  wire        chargeIndicatorIn,
  output reg         chargeIndicatorOut,
  output reg         chargeIndicatorOeN
);
  // Pump sequencer states
  localparam [2:0] PS_IDLE = 3'b001;
  localparam [2:0] PS_LOW  = 3'b010;
  localparam [2:0] PS_HIGH = 3'b100;

  reg  [21:0] syncA_r;
  reg  [21:0] syncB_r;
  reg  [31:0] wakeCnt_r;
  reg  [31:0] shipCnt_r;
  reg  [31:0] rstCnt_r;
  reg  [31:0] blinkCnt_r;
  reg  [31:0] alertCnt_r;
  reg  [31:0] pumpCnt_r;
  reg  [3:0]  pumpLeft_r;
  reg  [2:0]  pumpState_r;
  reg  [9:0]  ctrl_r;
  reg         pumpEn_r;
  reg         pumpUp_r;
  reg         pumpDn_r;
  reg  [4:0]  ilim_r;
  reg         shipOff_r;
  reg         rstOff_r;
  reg         blink_r;
  reg  [3:0]  faultRec_r;
  reg  [4:0]  flagRec_r;
  reg  [4:0]  prevLive_r;
  reg         awHave_r;
  reg         wHave_r;
  reg  [7:0]  awAddr_r;
  reg  [31:0] wData_r;
  reg  [3:0]  wStrb_r;
  reg  [9:0]  ctrl_nxt;
  reg  [8:0]  pump_nxt;
  reg  [31:0] rd_nxt;
  reg         pinSyncA_r;
  reg         pinSyncB_r;

  // Synchronised inputs
  wire sVbus   = syncB_r[0];
  wire sInRng  = syncB_r[1];
  wire sSleep  = syncB_r[2];
  wire sNoPoor = syncB_r[3];
  wire sTypeOk = syncB_r[4];
  wire sSrcDet = syncB_r[5];
  wire sChg    = syncB_r[6];
  wire sDone   = syncB_r[7];
  wire sChgEn  = syncB_r[8];
  wire sSusp   = |syncB_r[13:9];
  wire sIinReg = syncB_r[14];
  wire sVinReg = syncB_r[15];
  wire [3:0] sFault = syncB_r[19:16];
  wire sNtc    = syncB_r[20];
  wire sWakeN  = syncB_r[21];
  wire inGood  = sInRng & sSleep & sNoPoor & sTypeOk;

  wire wrGo  = awHave_r & wHave_r & ~s_axi_bvalid;
  wire rdGo  = s_axi_arvalid & s_axi_arready;
  wire wrCtl = wrGo & (awAddr_r == `CSC_OFS_CTRL);
  wire wrPmp = wrGo & (awAddr_r == `CSC_OFS_PUMP);
  wire rdFlt = rdGo & (s_axi_araddr == `CSC_OFS_FAULT);
  wire rdFlg = rdGo & (s_axi_araddr == `CSC_OFS_FLAG);
  wire [31:0] wMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
  wire [31:0] ctlMerged = ({22'h00_0000, ctrl_r} & ~wMask) | (wData_r & wMask);
  wire [31:0] pmpMerged = ({23'h00_0000, ilim_r, 1'b0, pumpDn_r, pumpUp_r, pumpEn_r} & ~wMask)
                          | (wData_r & wMask);

  // Wake low-time events
  wire wakeShip = ~sWakeN & (wakeCnt_r == SHIPMODE_CYC - 32'h0000_0001);
  wire wakeRst  = ~sWakeN & (wakeCnt_r == QON_RST_CYC - 32'h0000_0001);

  // Two-flop synchroniser for every pin input
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      syncA_r    <= 22'h20_0000;
      syncB_r    <= 22'h20_0000;
      pinSyncA_r <= 1'b1; // Pulled-up idle level
      pinSyncB_r <= 1'b1;
    end else begin
      pinSyncA_r <= chargeIndicatorIn;
      pinSyncB_r <= pinSyncA_r;
      syncA_r <= {wakeButtonN, thermistorFault, faultBatOv, faultCharge, faultBoost,
                  faultWatchdog, vinRegulating, iinRegulating, boostTsSuspend, suspendSysOv,
                  suspendTimer, suspendTs, suspendInOv, chargeEnabled, chargeDone, charging,
                  sourceDetected, typeDetectDone, sourceNotPoor, aboveSleep, vbusInRange,
                  vbusValid};
      syncB_r <= syncA_r;
    end
  end

  // Wake button low-time counter, restarts on high
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wakeCnt_r <= 32'h0000_0000;
    end else if (sWakeN) begin
      wakeCnt_r <= 32'h0000_0000;
    end else if (wakeCnt_r != QON_RST_CYC) begin
      wakeCnt_r <= wakeCnt_r + 32'h0000_0001;
    end
  end

  // Next control word after a bus write
  always @* begin
    ctrl_nxt = ctrl_r;
    if (wrCtl) begin
      ctrl_nxt = ctlMerged[9:0];
      ctrl_nxt[`CSC_CTRL_BOOST] = ctlMerged[`CSC_CTRL_BOOST] & ~ctlMerged[`CSC_CTRL_HIZ];
      if (ctlMerged[`CSC_CTRL_DEFAULTS]) begin
        ctrl_nxt = `CSC_CTRL_RESET;
      end
    end
    ctrl_nxt[`CSC_CTRL_DEFAULTS] = 1'b0;
    if (wakeShip) begin
      ctrl_nxt[`CSC_CTRL_BSD]   = 1'b0;
      ctrl_nxt[`CSC_CTRL_HIZ]   = 1'b1;
      ctrl_nxt[`CSC_CTRL_BOOST] = 1'b0;
    end
    pump_nxt = pmpMerged[8:0];
  end

  // Control register and adaptor pulse sequencer
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r      <= `CSC_CTRL_RESET;
      pumpEn_r    <= 1'b0;
      pumpUp_r    <= 1'b0;
      pumpDn_r    <= 1'b0;
      ilim_r      <= `CSC_ILIM_RESET;
      pumpState_r <= PS_IDLE;
      pumpCnt_r   <= 32'h0000_0000;
      pumpLeft_r  <= 4'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      if (wrCtl && ctlMerged[`CSC_CTRL_DEFAULTS]) begin
        pumpEn_r    <= 1'b0;
        pumpUp_r    <= 1'b0;
        pumpDn_r    <= 1'b0;
        ilim_r      <= `CSC_ILIM_RESET;
        pumpState_r <= PS_IDLE;
      end else if (wrPmp && !pump_nxt[`CSC_PUMP_EN]) begin
        pumpEn_r    <= 1'b0;
        ilim_r      <= pump_nxt[`CSC_PUMP_ILIM_HI:`CSC_PUMP_ILIM_LO];
        pumpUp_r    <= 1'b0;
        pumpDn_r    <= 1'b0;
        pumpState_r <= PS_IDLE;
      end else begin
        if (wrPmp) begin
          pumpEn_r <= 1'b1;
          ilim_r   <= pump_nxt[`CSC_PUMP_ILIM_HI:`CSC_PUMP_ILIM_LO];
        end
        case (pumpState_r)
          PS_IDLE: begin
            if (wrPmp && (pump_nxt[`CSC_PUMP_UP] || pump_nxt[`CSC_PUMP_DN])) begin
              pumpUp_r    <= pump_nxt[`CSC_PUMP_UP];
              pumpDn_r    <= ~pump_nxt[`CSC_PUMP_UP];
              pumpLeft_r  <= pump_nxt[`CSC_PUMP_UP] ? UP_PULSES : DN_PULSES;
              pumpCnt_r   <= 32'h0000_0000;
              pumpState_r <= PS_LOW;
            end
          end
          PS_LOW: begin
            if (pumpCnt_r == PUMP_ON_CYC - 32'h0000_0001) begin
              pumpCnt_r   <= 32'h0000_0000;
              pumpLeft_r  <= pumpLeft_r - 4'h1;
              pumpState_r <= PS_HIGH;
            end else begin
              pumpCnt_r <= pumpCnt_r + 32'h0000_0001;
            end
          end
          PS_HIGH: begin
            if (pumpCnt_r == PUMP_OFF_CYC - 32'h0000_0001) begin
              pumpCnt_r <= 32'h0000_0000;
              if (pumpLeft_r == 4'h0) begin
                pumpUp_r    <= 1'b0;
                pumpDn_r    <= 1'b0;
                pumpState_r <= PS_IDLE;
              end else begin
                pumpState_r <= PS_LOW;
              end
            end else begin
              pumpCnt_r <= pumpCnt_r + 32'h0000_0001;
            end
          end
          default: begin
            pumpState_r <= PS_IDLE;
          end
        endcase
      end
    end
  end

  // Ship-mode entry delay and forced power cycle
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shipOff_r <= 1'b0;
      shipCnt_r <= 32'h0000_0000;
      rstOff_r  <= 1'b0;
      rstCnt_r  <= 32'h0000_0000;
    end else begin
      if (!ctrl_r[`CSC_CTRL_BSD]) begin
        shipOff_r <= 1'b0;
        shipCnt_r <= 32'h0000_0000;
      end else if (!ctrl_r[`CSC_CTRL_DLY]) begin
        shipOff_r <= 1'b1;
      end else if (!shipOff_r) begin
        if (shipCnt_r == SHIP_DLY_CYC - 32'h0000_0001) begin
          shipOff_r <= 1'b1;
        end else begin
          shipCnt_r <= shipCnt_r + 32'h0000_0001;
        end
      end
      if (rstOff_r) begin
        if (rstCnt_r == SW_RST_CYC - 32'h0000_0001) begin
          rstOff_r <= 1'b0;
        end else begin
          rstCnt_r <= rstCnt_r + 32'h0000_0001;
        end
      end else if (wakeRst && !sVbus && !ctrl_r[`CSC_CTRL_BSD] &&
                   ctrl_r[`CSC_CTRL_RSTEN]) begin
        rstOff_r <= 1'b1;
        rstCnt_r <= 32'h0000_0000;
      end
    end
  end

  // Indicator blink timebase
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      blinkCnt_r <= 32'h0000_0000;
      blink_r    <= 1'b0;
    end else if (blinkCnt_r == BLINK_HALF_CYC - 32'h0000_0001) begin
      blinkCnt_r <= 32'h0000_0000;
      blink_r    <= ~blink_r;
    end else begin
      blinkCnt_r <= blinkCnt_r + 32'h0000_0001;
    end
  end

  // Fault and flag records, alert pulse
  wire [4:0] liveFlag = {sVinReg, sIinReg, inGood, sSrcDet, sDone};
  wire [4:0] dpmKeep  = ctrl_r[`CSC_CTRL_DPMMASK] ? 5'h07 : 5'h1F;
  wire [4:0] flagEvt  = {(liveFlag[4:3] & ~prevLive_r[4:3]),
                         (liveFlag[2] ^ prevLive_r[2]),
                         (liveFlag[1:0] & ~prevLive_r[1:0])} & dpmKeep;
  wire [3:0] faultEvt = sFault & ~faultRec_r;
  wire       recsIdle = (faultRec_r == 4'h0) & (flagRec_r == 5'h00);
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      faultRec_r <= 4'h0;
      flagRec_r  <= 5'h00;
      prevLive_r <= 5'h00;
      alertCnt_r <= 32'h0000_0000;
      hostAlertN <= 1'b1;
    end else begin
      prevLive_r <= liveFlag;
      faultRec_r <= (rdFlt ? 4'h0 : faultRec_r) | sFault;
      flagRec_r  <= (rdFlg ? 5'h00 : flagRec_r) | flagEvt;
      if (!hostAlertN) begin
        if (alertCnt_r == ALERT_CYC - 32'h0000_0001) begin
          hostAlertN <= 1'b1;
        end else begin
          alertCnt_r <= alertCnt_r + 32'h0000_0001;
        end
      end else if (((faultEvt != 4'h0) || (flagEvt != 5'h00)) && recsIdle) begin
        hostAlertN <= 1'b0;
        alertCnt_r <= 32'h0000_0000;
      end
    end
  end

  // Registered pin and control outputs
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      batterySwitchOn      <= 1'b1;
      inputHighImpedanceEn <= 1'b0;
      boostOutputEnable    <= 1'b0;
      limitIs100mA         <= 1'b0;
      inputCurrentLimit    <= `CSC_ILIM_RESET;
      inputGoodN           <= 1'b1;
      chargeIndicatorOut   <= 1'b0;
      chargeIndicatorOeN   <= 1'b1;
    end else begin
      batterySwitchOn      <= ~(shipOff_r | rstOff_r);
      inputHighImpedanceEn <= ctrl_r[`CSC_CTRL_HIZ];
      boostOutputEnable    <= ctrl_r[`CSC_CTRL_BOOST] & ~ctrl_r[`CSC_CTRL_HIZ];
      limitIs100mA         <= pumpState_r[1] & pumpEn_r;
      inputCurrentLimit    <= ilim_r;
      inputGoodN           <= ~inGood;
      chargeIndicatorOut   <= 1'b0;
      if (ctrl_r[`CSC_CTRL_MODE_HI]) begin
        chargeIndicatorOeN <= 1'b1;
      end else if (ctrl_r[`CSC_CTRL_MODE_LO]) begin
        chargeIndicatorOeN <= ctrl_r[`CSC_CTRL_MANUAL];
      end else if (sSusp) begin
        chargeIndicatorOeN <= blink_r;
      end else if (sChg && sChgEn && sSleep && !sDone) begin
        chargeIndicatorOeN <= 1'b0;
      end else begin
        chargeIndicatorOeN <= 1'b1;
      end
    end
  end

  // Read data mux
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (s_axi_araddr)
      `CSC_OFS_CTRL:   rd_nxt = {22'h00_0000, ctrl_r};
      `CSC_OFS_PUMP:   rd_nxt = {23'h00_0000, ilim_r, 1'b0, pumpDn_r, pumpUp_r, pumpEn_r};
      `CSC_OFS_FAULT:  rd_nxt = {27'h000_0000, sNtc, faultRec_r};
      `CSC_OFS_FLAG:   rd_nxt = {27'h000_0000, flagRec_r};
      `CSC_OFS_STATUS: rd_nxt = {24'h00_0000, pinSyncB_r, batterySwitchOn,
                                 sVbus, sVinReg, sIinReg, sNtc, 1'b0, inGood};
      default:         rd_nxt = 32'h0000_0000;
    endcase
  end

  wire addrOk = (s_axi_araddr == `CSC_OFS_CTRL) | (s_axi_araddr == `CSC_OFS_PUMP) |
                (s_axi_araddr == `CSC_OFS_FAULT) | (s_axi_araddr == `CSC_OFS_FLAG) |
                (s_axi_araddr == `CSC_OFS_STATUS);

  // AXI4-Lite handshakes
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h0000_0000;
      awHave_r      <= 1'b0;
      wHave_r       <= 1'b0;
      awAddr_r      <= 8'h00;
      wData_r       <= 32'h0000_0000;
      wStrb_r       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r      <= 1'b1;
        awAddr_r      <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r      <= 1'b1;
        wData_r      <= s_axi_wdata;
        wStrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrGo) begin
        awHave_r     <= 1'b0;
        wHave_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_r == `CSC_OFS_CTRL || awAddr_r == `CSC_OFS_PUMP) ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (rdGo) begin
        s_axi_rdata   <= rd_nxt;
        s_axi_rresp   <= addrOk ? 2'h0 : 2'h2;
        s_axi_rvalid  <= 1'b1;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // csc_top

// File: verification/csc_top_monitor.sv
module csc_top_monitor #(
  parameter [31:0] ALERT_CYC   = 10,
  parameter [31:0] PUMP_ON_CYC = 5
) (
  // Clock and reset
  input wire       sys_clk,
  input wire       rstn,
  // Read address channel and read data valid
  input wire [7:0] s_axi_araddr,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  // Input qualification
  input wire       vbusValid,
  input wire       vbusInRange,
  input wire       aboveSleep,
  input wire       sourceNotPoor,
  input wire       typeDetectDone,
  // Watched outputs
  input wire       hostAlertN,
  input wire       inputHighImpedanceEn,
  input wire       boostOutputEnable,
  input wire       limitIs100mA,
  input wire       inputGoodN,
  input wire       chargeIndicatorOut,
  input wire       batterySwitchOn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] lowCnt_r;
  logic [31:0] onCnt_r;
  logic        alerted_r;
  logic        rdFault_r;
  logic        rdFlag_r;
  wire         allGood = vbusInRange & aboveSleep & sourceNotPoor & typeDetectDone;
  wire         arTake  = s_axi_arvalid & s_axi_arready;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Pulse lengths and record reads since the last alert
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lowCnt_r  <= 32'h0;
      onCnt_r   <= 32'h0;
      alerted_r <= 1'b0;
      rdFault_r <= 1'b0;
      rdFlag_r  <= 1'b0;
    end else begin
      lowCnt_r <= hostAlertN ? 32'h0 : lowCnt_r + 32'h1;
      onCnt_r  <= limitIs100mA ? onCnt_r + 32'h1 : 32'h0;
      if ($fell(hostAlertN)) begin
        alerted_r <= 1'b1;
        rdFault_r <= 1'b0;
        rdFlag_r  <= 1'b0;
      end else if (arTake && s_axi_araddr[7:2] == 6'h02) begin
        rdFault_r <= 1'b1;
      end else if (arTake && s_axi_araddr[7:2] == 6'h03) begin
        rdFlag_r <= 1'b1;
      end
    end
  end

  a_alert_width: assert property ($rose(hostAlertN) |-> lowCnt_r == ALERT_CYC)
    else $error("alert pulse has the wrong width");
  a_alert_gate: assert property ($fell(hostAlertN) |-> !alerted_r || (rdFault_r && rdFlag_r))
    else $error("alert repeated before both records were read");
  a_boost_hiz: assert property (boostOutputEnable |-> !inputHighImpedanceEn)
    else $error("boost on while input high impedance");
  a_good_on: assert property ((allGood && vbusValid) [*5] |-> !inputGoodN)
    else $error("input good missing");
  a_good_off: assert property ((!allGood) [*5] |-> inputGoodN)
    else $error("input good without qualification");
  a_pump_len: assert property (limitIs100mA |-> onCnt_r < PUMP_ON_CYC)
    else $error("low current phase too long");
  a_ind_open: assert property (!chargeIndicatorOut)
    else $error("indicator driven high");
  a_rd_answer: assert property (arTake |=> s_axi_rvalid)
    else $error("read data late");

  // Main scenarios reached
  c_alert: cover property ($fell(hostAlertN));
  c_pump: cover property ($rose(limitIs100mA));
  c_switch: cover property ($fell(batterySwitchOn));
endmodule // csc_top_monitor

bind csc_top csc_top_monitor #(.ALERT_CYC(ALERT_CYC), .PUMP_ON_CYC(PUMP_ON_CYC)) i_csc_top_monitor (
  .sys_clk, .rstn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .vbusValid, .vbusInRange, .aboveSleep, .sourceNotPoor, .typeDetectDone, .hostAlertN,
  .inputHighImpedanceEn, .boostOutputEnable, .limitIs100mA, .inputGoodN,
  .chargeIndicatorOut, .batterySwitchOn
);

// File: verification/csc_pin_model.sv
module csc_pin_model (
  // Open-drain indicator from the device
  input wire logic drvOut,
  input wire logic drvOeN,
  // Level seen on the board
  output logic     pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  // Board pull-up wins while the device lets go
  assign pinLevel = drvOeN ? 1'b1 : drvOut;
endmodule // csc_pin_model

// File: verification/tb_charger_status_and_switch_control.sv
module tb_charger_status_and_switch_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rstn, wakeN, awValid, wValid, bReady, arValid, rReady;
  logic [7:0]  awAddr, arAddr;
  logic [31:0] wData, d;
  logic [3:0]  wStrb;
  logic [20:0] ana;
  logic [1:0]  r;
  logic [16:0] seed;
  int          failures, cmp_count, offN, lowN, limN, tog, i, j;
  int          ev[7] = '{16, 17, 18, 19, 5, 7, 14};
  wire         awR, wR, bV, arR, rV, bso, hiz, boost, lim, goodN, alertN, indOut, indOeN;
  wire         pinLevel;
  wire [1:0]   bResp, rResp;
  wire [31:0]  rData;
  wire [4:0]   ilim;

  csc_top #(
    .SHIP_DLY_CYC(200), .SHIPMODE_CYC(20), .QON_RST_CYC(100), .SW_RST_CYC(30),
    .BLINK_HALF_CYC(8), .ALERT_CYC(10), .PUMP_ON_CYC(5), .PUMP_OFF_CYC(5)
  ) i_csc_top (
    .sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awR), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wR), .s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arR),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rReady),
    .vbusValid(ana[0]), .vbusInRange(ana[1]), .aboveSleep(ana[2]), .sourceNotPoor(ana[3]),
    .typeDetectDone(ana[4]), .sourceDetected(ana[5]), .charging(ana[6]),
    .chargeDone(ana[7]), .chargeEnabled(ana[8]), .suspendInOv(ana[9]),
    .suspendTs(ana[10]), .suspendTimer(ana[11]), .suspendSysOv(ana[12]),
    .boostTsSuspend(ana[13]), .iinRegulating(ana[14]), .vinRegulating(ana[15]),
    .faultWatchdog(ana[16]), .faultBoost(ana[17]), .faultCharge(ana[18]),
    .faultBatOv(ana[19]), .thermistorFault(ana[20]), .wakeButtonN(wakeN),
    .batterySwitchOn(bso), .inputHighImpedanceEn(hiz), .boostOutputEnable(boost),
    .limitIs100mA(lim), .inputCurrentLimit(ilim), .inputGoodN(goodN), .hostAlertN(alertN),
    .chargeIndicatorIn(pinLevel), .chargeIndicatorOut(indOut), .chargeIndicatorOeN(indOeN)
  );

  csc_pin_model i_csc_pin_model (.drvOut(indOut), .drvOeN(indOeN), .pinLevel(pinLevel));

  // Free-running system clock
  always #5 sys_clk = ~sys_clk;

  // Pseudo-random source
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  // Expected power-good pin level
  function automatic logic goodExp(input logic [3:0] v);
    return ~&v;
  endfunction

  task automatic wrap_up();
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Clock cycles with event counting
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      offN += !bso;
      lowN += !alertN;
      limN += lim;
      tog += !pinLevel;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    cyc(1);
    awAddr <= a;
    wData <= v;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (n = 0; n < 40 && !(bV && bReady); n++) begin
      cyc(1);
      if (awR) awValid <= 1'b0;
      if (wR) wValid <= 1'b0;
    end
    r = bResp;
    bReady <= 1'b0;
    if (n == 40) begin failures++; wrap_up(); end
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    cyc(1);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (n = 0; n < 40 && !(rV && rReady); n++) begin
      cyc(1);
      if (arR) arValid <= 1'b0;
    end
    d = rData;
    r = rResp;
    rReady <= 1'b0;
    if (n == 40) begin failures++; wrap_up(); end
  endtask

  // Push-button held low for n cycles
  task automatic press(input int n);
    cyc(1);
    offN = 0;
    wakeN <= 1'b0;
    cyc(n);
    wakeN <= 1'b1;
    cyc(60);
  endtask

  initial begin
    {sys_clk, rstn, awValid, wValid, bReady, arValid, rReady} = '0;
    {awAddr, arAddr, wData} = '0;
    wStrb = 4'hF;
    wakeN = 1'b1;
    ana = 21'h00_0101;
    seed = 17'h1_10AE;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    cyc(3);
    // Reset values and refused accesses
    rd(8'h00); chk(d, 32'h0000_0004);
    rd(8'h04); chk(d, 32'h0000_0080);
    rd(8'h14); chk(r, 2'b10);
    wr(8'h08, 32'h0000_0001); chk(r, 2'b10);
    // Byte lane strobe keeps the other lanes
    wStrb <= 4'h2;
    wr(8'h00, 32'hFFFF_FF00); rd(8'h00); chk(d, 32'h0000_0304);
    wStrb <= 4'hF;
    wr(8'h00, 32'h0000_0004);
    // Input good qualification
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      ana[4:1] <= seed[3:0] | {4{seed[4]}};
      cyc(6);
      chk(goodN, goodExp(seed[3:0] | {4{seed[4]}}));
    end
    // Ship entry and exit while supplied
    wr(8'h00, 32'h0000_0005); cyc(3); chk(bso, 1'b0);
    wr(8'h00, 32'h0000_0004); cyc(3); chk(bso, 1'b1);
    wr(8'h00, 32'h0000_0007); cyc(20); chk(bso, 1'b1);
    cyc(200); chk(bso, 1'b0);
    wr(8'h00, 32'h0000_0020); cyc(3); chk(bso, 1'b1);
    // Push-button exit without supply
    ana[0] <= 1'b0;
    wr(8'h00, 32'h0000_0005); cyc(3);
    press(10); chk(bso, 1'b0);
    press(30); chk(bso, 1'b1);
    chk(hiz, 1'b1);
    wr(8'h00, 32'h0000_001C); cyc(3); chk(boost, 1'b0);
    wr(8'h00, 32'h0000_0014); cyc(3); chk(boost, 1'b1);
    // Forced power cycle, then with it disallowed
    wr(8'h00, 32'h0000_0004); press(130); chk(offN, 30);
    wr(8'h00, 32'h0000_0000); press(130); chk(offN, 0);
    // Charge indicator
    ana[4:1] <= 4'hF;
    ana[6] <= 1'b1; cyc(5); chk(pinLevel, 1'b0);
    ana[7:6] <= 2'b10; cyc(5); chk(pinLevel, 1'b1);
    ana[8:6] <= 3'b001; cyc(5); chk(pinLevel, 1'b1);
    for (j = 9; j < 14; j++) begin
      ana[j] <= 1'b1;
      cyc(4);
      tog = 0;
      cyc(40);
      ana[j] <= 1'b0;
      chk(tog > 12 && tog < 28, 1'b1);
    end
    ana[8:6] <= 3'b101;
    wr(8'h00, 32'h0000_0140); cyc(3); chk(pinLevel, 1'b1);
    wr(8'h00, 32'h0000_0040); cyc(3); chk(pinLevel, 1'b0);
    wr(8'h00, 32'h0000_0080); cyc(3); chk(pinLevel, 1'b1);
    wr(8'h00, 32'h0000_00C0); cyc(3); chk(pinLevel, 1'b1);
    ana[6] <= 1'b0;
    // Alert sources, each after the records were emptied
    for (i = 0; i < 7; i++) begin
      rd(8'h08); rd(8'h0C); rd(8'h08); rd(8'h0C);
      lowN = 0;
      ana[ev[i]] <= 1'b1;
      cyc(20);
      ana[ev[i]] <= 1'b0;
      chk(lowN, 10);
    end
    ana[15:14] <= 2'b11; cyc(5); rd(8'h10); chk(d[4:3], 2'b11);
    ana[15:14] <= 2'b00;
    rd(8'h08); rd(8'h0C); rd(8'h08); rd(8'h0C);
    lowN = 0;
    ana[16] <= 1'b1; cyc(20);
    ana[17] <= 1'b1; cyc(20); chk(lowN, 10);
    ana[17:16] <= 2'b00; cyc(4);
    rd(8'h08); chk(d, 32'h0000_0003);
    rd(8'h08); chk(d, 32'h0000_0000);
    ana[20] <= 1'b1; cyc(4); rd(8'h08); chk(d, 32'h0000_0010);
    ana[20] <= 1'b0; cyc(4); rd(8'h08); chk(d, 32'h0000_0000);
    // Adaptor current pulses
    seed = lfsr(seed);
    limN = 0; wr(8'h04, {23'h0, seed[4:0], 4'h3}); cyc(60); chk(limN, 15);
    chk(ilim, seed[4:0]);
    rd(8'h04); chk(d, {23'h0, seed[4:0], 4'h1});
    limN = 0; wr(8'h04, {23'h0, seed[4:0], 4'h5}); cyc(60); chk(limN, 10);
    wr(8'h04, {23'h0, seed[4:0], 4'h3}); cyc(2);
    wr(8'h04, {23'h0, seed[4:0], 4'h0}); cyc(2);
    limN = 0; cyc(30); chk(limN, 0);
    chk(ilim, seed[4:0]);
    wr(8'h04, {23'h0, seed[4:0], 4'h2}); cyc(30); chk(limN, 0);
    rd(8'h04); chk(d[2:0], 3'h0);
    wrap_up();
  end
endmodule // tb_charger_status_and_switch_control
